// file: lsef_event_flags.sv
// Purpose: light count result, threshold compare and event flag byte
// Assumes: requests and measurements come from logic on i_clk_sys
// Notes:   reading the flag byte clears the flags it reported
`timescale 1ns/1ns
`default_nettype none
module lsef_event_flags
  import lsef_pkg::*;
#(
  parameter logic [IT_W-1:0] P_SHORTEST_IT  = SHORTEST_IT_CODE,
  parameter logic [15:0]     P_SHORTEST_MAX = SHORTEST_IT_MAX
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire lsef_req_t  i_req,
  input  wire lsef_meas_t i_meas,
  output logic [7:0]      o_rdata,
  output logic            o_rvalid,
  output logic [15:0]     o_upper_limit,
  output logic [15:0]     o_lower_limit
);

  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [15:0] count_q, count_d;
  logic [7:0]  high_snap_q, high_snap_d;
  logic        ready_q, ready_d;
  logic        under_q, under_d;
  logic        over_q, over_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        rvalid_q, rvalid_d;
  logic [15:0] new_count;
  logic [7:0]  flag_byte;
  logic        flag_read;

  // the shortest window cannot reach full range, so the core value is held
  // to its ceiling instead of letting it alias
  always_comb begin
    new_count = i_meas.count;
    if ((i_meas.window == P_SHORTEST_IT) &&
        (i_meas.count > P_SHORTEST_MAX)) begin
      new_count = P_SHORTEST_MAX;
    end
  end

  always_comb begin
    flag_byte                 = RESERVED_VALUE;
    flag_byte[FLAG_READY_BIT] = ready_q;
    flag_byte[FLAG_UNDER_BIT] = under_q;
    flag_byte[FLAG_OVER_BIT]  = over_q;
  end

  assign flag_read = i_req.rd && (i_req.cmd == CMD_EVENT_FLAGS);

  // threshold registers; reserved and result codes match neither pair,
  // so writes to them are dropped
  lsef_limit_pair #(
    .P_LOW_CMD  (CMD_UPPER_LIMIT_LOW),
    .P_HIGH_CMD (CMD_UPPER_LIMIT_HIGH),
    .P_RESET    (UPPER_LIMIT_RESET)
  ) u_upper_limit (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_req     (i_req),
    .o_value   (upper_q)
  );

  lsef_limit_pair #(
    .P_LOW_CMD  (CMD_LOWER_LIMIT_LOW),
    .P_HIGH_CMD (CMD_LOWER_LIMIT_HIGH),
    .P_RESET    (LOWER_LIMIT_RESET)
  ) u_lower_limit (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_req     (i_req),
    .o_value   (lower_q)
  );

  // result capture and event flags; a new event beats a same-cycle clear
  always_comb begin
    count_d = count_q;
    ready_d = ready_q;
    under_d = under_q;
    over_d  = over_q;
    if (flag_read) begin
      ready_d = 1'b0;
      under_d = 1'b0;
      over_d  = 1'b0;
    end
    if (i_meas.valid) begin
      count_d = new_count;
      if (i_meas.forced) begin
        ready_d = 1'b1;
      end
      if (new_count < lower_q) begin
        under_d = 1'b1;
      end
      if (new_count > upper_q) begin
        over_d = 1'b1;
      end
    end
  end

  // reading the low byte freezes the high byte so the pair stays coherent
  // even if a new result lands between the two reads
  always_comb begin
    high_snap_d = high_snap_q;
    rdata_d     = rdata_q;
    rvalid_d    = i_req.rd;
    if (i_req.rd) begin
      unique case (i_req.cmd)
        CMD_UPPER_LIMIT_LOW: begin
          rdata_d = upper_q[7:0];
        end
        CMD_UPPER_LIMIT_HIGH: begin
          rdata_d = upper_q[15:8];
        end
        CMD_LOWER_LIMIT_LOW: begin
          rdata_d = lower_q[7:0];
        end
        CMD_LOWER_LIMIT_HIGH: begin
          rdata_d = lower_q[15:8];
        end
        CMD_LIGHT_COUNT_LOW: begin
          rdata_d     = count_q[7:0];
          high_snap_d = count_q[15:8];
        end
        CMD_LIGHT_COUNT_HIGH: begin
          rdata_d = high_snap_q;
        end
        CMD_RESERVED_STATUS: begin
          rdata_d = RESERVED_VALUE;
        end
        CMD_EVENT_FLAGS: begin
          rdata_d = flag_byte;
        end
        default: begin
          rdata_d = RDATA_RESET;
        end
      endcase
    end
  end

  // result and flag state
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      count_q <= LIGHT_COUNT_RESET;
      ready_q <= 1'b0;
      under_q <= 1'b0;
      over_q  <= 1'b0;
    end else begin
      count_q <= count_d;
      ready_q <= ready_d;
      under_q <= under_d;
      over_q  <= over_d;
    end
  end

  // read answer state
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      high_snap_q <= LIGHT_COUNT_RESET[15:8];
      rdata_q     <= RDATA_RESET;
      rvalid_q    <= 1'b0;
    end else begin
      high_snap_q <= high_snap_d;
      rdata_q     <= rdata_d;
      rvalid_q    <= rvalid_d;
    end
  end

  assign o_rdata       = rdata_q;
  assign o_rvalid      = rvalid_q;
  assign o_upper_limit = upper_q;
  assign o_lower_limit = lower_q;

endmodule // lsef_event_flags

module lsef_limit_pair
  import lsef_pkg::*;
#(
  parameter logic [7:0]  P_LOW_CMD  = CMD_UPPER_LIMIT_LOW,
  parameter logic [7:0]  P_HIGH_CMD = CMD_UPPER_LIMIT_HIGH,
  parameter logic [15:0] P_RESET    = UPPER_LIMIT_RESET
) (
  input  wire logic      i_clk_sys,
  input  wire logic      i_rst_n,
  input  wire lsef_req_t i_req,
  output logic [15:0]    o_value
);

  logic [15:0] value_q, value_d;

  // each byte lands on its own write; no pairing latch, so a host that
  // changes both bytes sees a mixed limit for the cycles in between
  always_comb begin
    value_d = value_q;
    if (i_req.wr && (i_req.cmd == P_LOW_CMD)) begin
      value_d[7:0] = i_req.wdata;
    end
    if (i_req.wr && (i_req.cmd == P_HIGH_CMD)) begin
      value_d[15:8] = i_req.wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      value_q <= P_RESET;
    end else begin
      value_q <= value_d;
    end
  end

  assign o_value = value_q;

endmodule // lsef_limit_pair
`default_nettype wire

// file: lsef_pkg.sv
// Purpose: constants and carriers for the light sensor event flag block
// Assumes: one system clock, command-coded byte register access
// Notes:   shared by the design and by the verification side
`default_nettype none
package lsef_pkg;

  // command codes
  localparam logic [7:0] CMD_UPPER_LIMIT_LOW  = 8'h04;
  localparam logic [7:0] CMD_UPPER_LIMIT_HIGH = 8'h05;
  localparam logic [7:0] CMD_LOWER_LIMIT_LOW  = 8'h06;
  localparam logic [7:0] CMD_LOWER_LIMIT_HIGH = 8'h07;
  localparam logic [7:0] CMD_LIGHT_COUNT_LOW  = 8'h10;
  localparam logic [7:0] CMD_LIGHT_COUNT_HIGH = 8'h11;
  localparam logic [7:0] CMD_RESERVED_STATUS  = 8'h16;
  localparam logic [7:0] CMD_EVENT_FLAGS      = 8'h17;

  // event flag byte layout
  localparam int unsigned FLAG_READY_BIT = 3;
  localparam int unsigned FLAG_UNDER_BIT = 2;
  localparam int unsigned FLAG_OVER_BIT  = 1;

  // values after reset
  localparam logic [15:0] UPPER_LIMIT_RESET = 16'h0000;
  localparam logic [15:0] LOWER_LIMIT_RESET = 16'h0000;
  localparam logic [15:0] LIGHT_COUNT_RESET = 16'h0000;
  localparam logic [7:0]  RESERVED_VALUE    = 8'h00;
  localparam logic [7:0]  RDATA_RESET       = 8'h00;

  // integration window code width and plain defaults for the core coupling
  localparam int unsigned IT_W              = 3;
  localparam logic [2:0]  SHORTEST_IT_CODE  = 3'h7;
  localparam logic [15:0] SHORTEST_IT_MAX   = 16'h7fff;

  // register access request from the serial front end
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] cmd;
    logic [7:0] wdata;
  } lsef_req_t;

  // one finished measurement from the sensor core
  typedef struct packed {
    logic        valid;
    logic        forced;
    logic [2:0]  window;
    logic [15:0] count;
  } lsef_meas_t;

endpackage : lsef_pkg
`default_nettype wire

// file: lsef_assertions.sv
// Purpose: port assertions for lsef_event_flags
// Assumes: default limits, one host access at a time
// Notes:   flags are read two cycles after a measurement
`timescale 1ns/1ns
`default_nettype none
module lsef_assertions
  import lsef_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  input wire lsef_req_t   i_req,
  input wire lsef_meas_t  i_meas,
  input wire logic [7:0]  o_rdata,
  input wire logic [15:0] o_upper_limit,
  input wire logic [15:0] o_lower_limit
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic rf, rc, r16, nm, mv;
  assign rf = i_req.rd && i_req.cmd == CMD_EVENT_FLAGS;
  assign rc = i_req.rd && i_req.cmd == CMD_LIGHT_COUNT_LOW;
  assign r16 = i_req.rd && i_req.cmd == CMD_RESERVED_STATUS;
  assign nm = !i_meas.valid;
  assign mv = i_meas.valid && i_meas.window != SHORTEST_IT_CODE;
  rsvd_byte_a:
    assert property (r16 |=> o_rdata == 8'h00) else $error("reserved byte");
  rsvd_bits_a:
    assert property (rf |=> o_rdata[7:4] == 4'h0 && !o_rdata[0])
      else $error("reserved flag bits");
  ready_flag_a:
    assert property (i_meas.valid && i_meas.forced ##1 !rf ##1 rf
      |=> o_rdata[3]) else $error("ready flag missing");
  under_flag_a:
    assert property (i_meas.valid && i_meas.count < o_lower_limit ##1 !rf
      ##1 rf |=> o_rdata[2]) else $error("under flag missing");
  over_flag_a:
    assert property (mv && i_meas.count > o_upper_limit ##1 !rf ##1 rf
      |=> o_rdata[1]) else $error("over flag missing");
  flag_clear_a:
    assert property (rf && nm ##1 nm ##1 rf && nm |=> o_rdata == 8'h00)
      else $error("flags not cleared");
  count_low_a:
    assert property (mv ##1 nm ##1 rc && nm
      |=> o_rdata == $past(i_meas.count[7:0], 3)) else $error("count low");
  count_clamp_a:
    assert property (i_meas.valid && !mv && i_meas.count > SHORTEST_IT_MAX
      ##1 nm ##1 rc && nm |=> o_rdata == SHORTEST_IT_MAX[7:0])
      else $error("count not clamped");
  cover property (rf ##2 rf);
  cover property (i_meas.valid && !mv);
  cover property (r16);
endmodule // lsef_assertions
bind lsef_event_flags lsef_assertions u_chk (.i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n), .i_req(i_req), .i_meas(i_meas), .o_rdata(o_rdata),
  .o_upper_limit(o_upper_limit), .o_lower_limit(o_lower_limit));
`default_nettype wire

// file: lsef_host.sv
// Purpose: host model issuing single byte reads and writes
// Assumes: read answer comes exactly one cycle after the request
// Notes:   no ready to wait for, so requests last one cycle
`timescale 1ns/1ns
`default_nettype none
module lsef_host
  import lsef_pkg::*;
(
  input  wire logic     i_clk_sys,
  output var lsef_req_t o_req
);
  initial o_req = '0;
  // resolution in 0.0001 lx per count: 26 at 400 ms and gain x2, doubled
  // per halving of window or gain; table rounding is left to the host
  function automatic int unsigned res_e4(input int unsigned halvings);
    return 26 << halvings;
  endfunction
  task automatic xfer(input logic rd, input logic [7:0] cmd, wd);
    @(posedge i_clk_sys);
    o_req <= '{rd, !rd, cmd, wd};
    @(posedge i_clk_sys);
    o_req <= '0;
  endtask
endmodule // lsef_host
`default_nettype wire

// file: light_sensor_event_flags_tb.sv
// Purpose: self-checking bench for lsef_event_flags
// Assumes: one access or measurement at a time
// Notes:   window code 7 only in the clamp case, compare order unclear
`timescale 1ns/1ns
`default_nettype none
module light_sensor_event_flags_tb;
  import lsef_pkg::*;
  logic       i_clk_sys = 1'b0;
  logic       i_rst_n = 1'b0;
  lsef_req_t  req;
  lsef_meas_t meas = '0;
  logic [7:0] rdata, ch = 8'h00, e;
  logic [15:0] ul, ll;
  logic       rvalid;
  logic [7:0] m[256] = '{default: 8'h00};
  int         miscompares = 0, comparisons = 0, cyc = 0;
  always #20 i_clk_sys = ~i_clk_sys;
  lsef_host host (.i_clk_sys(i_clk_sys), .o_req(req));
  lsef_event_flags DUT (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_req(req), .i_meas(meas), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_upper_limit(ul), .o_lower_limit(ll));
  task automatic rd(input logic [7:0] c);
    e = (c inside {[8'h04:8'h07], 8'h10, 8'h11, 8'h17}) ? m[c] : 8'h00;
    if (c == 8'h10) m[8'h11] = ch;
    if (c == 8'h17) m[8'h17] = 8'h00;
    host.xfer(1'b1, c, 8'h00);
    @(negedge i_clk_sys);
    comparisons++;
    if (rvalid !== 1'b1 || rdata !== e) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, rdata, e);
    end
    comparisons++;
    if ({ul, ll} !== {m[5], m[4], m[7], m[6]}) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, {ul, ll},
        {m[5], m[4], m[7], m[6]});
    end
  endtask
  task automatic ms(input logic f, input logic [2:0] w, input logic [15:0] c);
    @(posedge i_clk_sys);
    meas <= '{1'b1, f, w, c};
    @(posedge i_clk_sys);
    meas <= '0;
    if (w == SHORTEST_IT_CODE && c > SHORTEST_IT_MAX) c = SHORTEST_IT_MAX;
    m[8'h10] = c[7:0];
    ch = c[15:8];
    m[8'h17] |= {4'h0, f, c < {m[7], m[6]}, c > {m[5], m[4]}, 1'b0};
  endtask
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    logic [7:0] c, d;
    void'($urandom(16649));
    repeat (8) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    ms(1'b1, SHORTEST_IT_CODE, 16'hffff);
    rd(8'h10);
    rd(8'h11);
    rd(8'h17);
    rd(8'h17);
    repeat (300) begin
      c = 8'h04 + 8'($urandom % 4);
      d = 8'($urandom);
      case ($urandom % 4)
        0: begin
          host.xfer(1'b0, c, d);
          m[c] = d;
        end
        1: ms(1'($urandom), 3'($urandom % 7), 16'($urandom));
        default: rd(d[0] ? c : 8'h10 + {4'h0, d[3:1], d[4]});
      endcase
    end
    comparisons++;
    if (host.res_e4(2) != 104) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time,
        host.res_e4(2), 104);
    end
    give_verdict();
  end
endmodule // light_sensor_event_flags_tb
`default_nettype wire
